/* File: logic/spi_fifo_port_pkg.sv */
// Shared constants, types and field layout for the serial register port with receive queue
package spi_fifo_port_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int QUEUE_DEPTH = 66;
  localparam int LEVEL_W = 7;
  localparam int NUM_REGS = 128;
  localparam logic [ADDR_W-1:0] QUEUE_ADDR = 7'h00;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 7'h28;
  localparam logic [ADDR_W-1:0] THRESH_ADDR = 7'h3c;
  localparam logic [DATA_W-1:0] THRESH_RESET = 8'h0f;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] EMPTY_READ = 8'h00;
  // Layout of the flags register
  localparam int FLAG_OVERRUN = 4;
  localparam int FLAG_LEVEL = 5;
  localparam int FLAG_NONEMPTY = 6;
  localparam int FLAG_FULL = 7;
  localparam int DIR_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_STDBY, MODE_FS, MODE_RX} opMode_e;

  typedef struct packed {
    logic sck;
    logic nss;
    logic mosi;
  } spiPins_s;

  typedef struct packed {
    logic full;
    logic nonempty;
    logic level;
    logic overrun;
  } queueFlags_s;
endpackage

/* File: logic/spi_register_fifo_port.sv */
// Serial register port, receive deserializer and byte queue
`timescale 1ns/1ps
`default_nettype none

module byte_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic clr, // Empty the queue
  input wire logic [WIDTH-1:0] inData, // Write data
  input wire logic inValid, // Write request
  output logic inReady, // Room for a write
  output logic [WIDTH-1:0] outData, // Head entry
  output logic outValid, // Head entry present
  input wire logic outReady, // Head consumed
  output logic [$clog2(DEPTH+1)-1:0] level // Entries held
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [$clog2(DEPTH+1)-1:0] FULL_LEVEL = ($clog2(DEPTH+1))'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  wire logic doPush;
  wire logic doPop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign inReady = (count_r != FULL_LEVEL);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign level = count_r;
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  always_ff @(posedge ref_clk)
  begin
    if (doPush)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || clr)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= bump(wrPtr_r);
      if (doPop)
        rdPtr_r <= bump(rdPtr_r);
      count_r <= count_r + {{($clog2(DEPTH+1)-1){1'b0}}, doPush} - {{($clog2(DEPTH+1)-1){1'b0}}, doPop};
    end
  end
endmodule

module spi_register_fifo_port
  import spi_fifo_port_pkg::*;
(
  input wire logic ref_clk, // 100 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire spiPins_s spiIn, // SCK, NSS and MOSI pins
  output logic miso, // Serial data to host
  output logic misoOe, // High while driving MISO
  input wire opMode_e opMode, // Operating mode of the receiver
  input wire logic packetMode, // 1 packet operation, 0 continuous
  input wire logic demodBit, // Demodulated bit
  input wire logic demodValid, // One-cycle strobe for demodBit
  output logic serialDataPin, // Live data in continuous operation
  output logic queueNonempty, // queue_nonempty
  output logic queueFull, // queue_full
  output logic queueOverrun, // queue_overrun
  output logic queueLevelFlag // queue_level_flag
);
  spiPins_s sync1_r;
  spiPins_s sync2_r;
  logic sckPrev_r;
  logic nssPrev_r;
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [DATA_W-2:0] rxShift_r;
  logic [2:0] bitCnt_r;
  logic inAddr_r;
  logic wnr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] txShift_r;
  logic misoBit_r;
  logic popPend_r;
  logic nonemptyHold_r;
  logic [DATA_W-2:0] desShift_r;
  logic [2:0] desCnt_r;
  logic pushValid_r;
  logic [DATA_W-1:0] pushData_r;
  logic overrun_r;
  logic overrun_nxt;
  opMode_e prevMode_r;
  logic serialData_r;

  wire logic sckRise;
  wire logic sckFall;
  wire logic nssFall;
  wire logic frameOn;
  wire logic byteDone;
  wire logic [DATA_W-1:0] rxByte;
  wire logic [ADDR_W-1:0] nextAddr;
  wire logic dataWrite;
  wire logic overrunClr;
  wire logic enterRx;
  wire logic flush;
  wire logic collect;
  wire logic desDone;
  wire logic pushReady;
  wire logic [DATA_W-1:0] headData;
  wire logic headValid;
  wire logic popNow;
  wire logic [LEVEL_W-1:0] queueLevel;
  wire logic [LEVEL_W-1:0] threshold;
  wire queueFlags_s flags;
  wire logic [DATA_W-1:0] loadByte;

  // Edges are found only after the two-stage synchroniser
  assign sckRise = sync2_r.sck & ~sckPrev_r;
  assign sckFall = ~sync2_r.sck & sckPrev_r;
  assign nssFall = ~sync2_r.nss & nssPrev_r;
  assign frameOn = ~sync2_r.nss;
  assign byteDone = frameOn & sckRise & (bitCnt_r == LAST_BIT);
  assign rxByte = {rxShift_r, sync2_r.mosi};
  // Queue address is sticky, every other address walks upward
  assign nextAddr = inAddr_r ? rxByte[ADDR_W-1:0] :
    (addr_r == QUEUE_ADDR) ? addr_r : addr_r + 1'b1;
  assign dataWrite = byteDone & ~inAddr_r & wnr_r;
  assign overrunClr = dataWrite & (addr_r == FLAGS_ADDR) & rxByte[FLAG_OVERRUN];
  assign enterRx = (opMode == MODE_RX) &
    ((prevMode_r == MODE_SLEEP) | (prevMode_r == MODE_STDBY));
  assign flush = overrunClr | enterRx;
  assign collect = demodValid & packetMode & (opMode == MODE_RX);
  assign desDone = collect & (desCnt_r == LAST_BIT);
  // Pop only once the host clocks in the first bit of the byte, so a frame ended at a byte boundary loses nothing
  assign popNow = frameOn & sckRise & popPend_r;
  assign threshold = regs[THRESH_ADDR][LEVEL_W-1:0];
  assign flags.full = ~pushReady;
  assign flags.nonempty = nonemptyHold_r;
  assign flags.level = queueLevel > threshold;
  assign flags.overrun = overrun_r;
  assign overrun_nxt = (pushValid_r & ~pushReady) | (overrun_r & ~overrunClr);

  // Value presented for the byte that follows; an empty queue yields a filler byte
  function automatic logic [DATA_W-1:0] readValue(input logic [ADDR_W-1:0] a,
                                                  input queueFlags_s f,
                                                  input logic [DATA_W-1:0] r,
                                                  input logic [DATA_W-1:0] head,
                                                  input logic hv);
    if (a == QUEUE_ADDR)
      readValue = hv ? head : EMPTY_READ;
    else if (a == FLAGS_ADDR)
      readValue = {f, 4'h0};
    else
      readValue = r;
  endfunction

  // Old content of the next register is loaded before any write lands
  assign loadByte = readValue(nextAddr, flags, regs[nextAddr], headData, headValid);

  byte_queue #(
    .WIDTH(DATA_W),
    .DEPTH(QUEUE_DEPTH)
  ) rxQueue (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(flush),
    .inData(pushData_r),
    .inValid(pushValid_r),
    .inReady(pushReady),
    .outData(headData),
    .outValid(headValid),
    .outReady(popNow),
    .level(queueLevel)
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r <= '{sck: 1'b0, nss: 1'b1, mosi: 1'b0};
      sync2_r <= '{sck: 1'b0, nss: 1'b1, mosi: 1'b0};
      sckPrev_r <= 1'b0;
      nssPrev_r <= 1'b1;
    end
    else
    begin
      sync1_r <= spiIn;
      sync2_r <= sync1_r;
      sckPrev_r <= sync2_r.sck;
      nssPrev_r <= sync2_r.nss;
    end
  end

  // Serial engine: slave only, sample on rise, shift out on fall
  always_ff @(posedge ref_clk)
  begin
    if (rst || !frameOn)
    begin
      bitCnt_r <= FIRST_BIT;
      inAddr_r <= 1'b1;
      rxShift_r <= '0;
      txShift_r <= '0;
      popPend_r <= 1'b0;
      if (rst)
      begin
        wnr_r <= 1'b0;
        addr_r <= QUEUE_ADDR;
        misoBit_r <= 1'b0;
      end
    end
    else
    begin
      if (sckRise)
      begin
        rxShift_r <= rxByte[DATA_W-2:0];
        bitCnt_r <= bitCnt_r + 1'b1;
        popPend_r <= 1'b0;
      end
      if (byteDone)
      begin
        inAddr_r <= 1'b0;
        addr_r <= nextAddr;
        txShift_r <= loadByte;
        popPend_r <= (nextAddr == QUEUE_ADDR) & (inAddr_r ? ~rxByte[DIR_BIT] : ~wnr_r) &
          headValid;
        if (inAddr_r)
          wnr_r <= rxByte[DIR_BIT];
      end
      else if (sckFall)
      begin
        misoBit_r <= txShift_r[DATA_W-1];
        txShift_r <= {txShift_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  assign miso = misoBit_r;
  assign misoOe = frameOn;

  // Register file; queue and flags addresses are not plain storage
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= (ADDR_W'(i) == THRESH_ADDR) ? THRESH_RESET : REG_RESET;
    end
    else if (dataWrite && addr_r != QUEUE_ADDR && addr_r != FLAGS_ADDR)
      regs[addr_r] <= rxByte;
  end

  // Deserializer, MSB first, plus status and mode tracking
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      desShift_r <= '0;
      desCnt_r <= FIRST_BIT;
      pushValid_r <= 1'b0;
      pushData_r <= '0;
      overrun_r <= 1'b0;
      prevMode_r <= MODE_SLEEP;
      nonemptyHold_r <= 1'b0;
      serialData_r <= 1'b0;
    end
    else
    begin
      prevMode_r <= opMode;
      overrun_r <= overrun_nxt;
      pushValid_r <= desDone & ~flush;
      if (desDone)
        pushData_r <= {desShift_r, demodBit};
      if (flush)
        desCnt_r <= FIRST_BIT;
      else if (collect)
      begin
        desShift_r <= {desShift_r[DATA_W-3:0], demodBit};
        desCnt_r <= desCnt_r + 1'b1;
      end
      // Held through a frame so a started read is never cut short
      if (!frameOn || nssFall)
        nonemptyHold_r <= headValid;
      if (demodValid && !packetMode && opMode == MODE_RX)
        serialData_r <= demodBit;
    end
  end

  assign serialDataPin = serialData_r;
  assign queueNonempty = nonemptyHold_r;
  assign queueFull = flags.full;
  assign queueOverrun = overrun_r;
  assign queueLevelFlag = flags.level;
endmodule

`default_nettype wire

/* File: sim/spi_port_checker.sv */
// Concurrent checks on the serial port and receive queue pins
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker
  import spi_fifo_port_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire spiPins_s spiIn, // Host pins
  input wire logic miso, // Data out
  input wire logic misoOe, // Data enable
  input wire opMode_e opMode, // Mode
  input wire logic packetMode, // Packet select
  input wire logic demodBit, // Bit in
  input wire logic demodValid, // Bit strobe
  input wire logic serialDataPin, // Live bit
  input wire logic queueNonempty, // Not empty
  input wire logic queueFull, // Full
  input wire logic queueOverrun, // Overrun
  input wire logic queueLevelFlag // Level
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Six cycles covers the two-flop synchroniser plus the registered flag
  sequence nssIdle;
    spiIn.nss [*6];
  endsequence
  sequence nssBusy;
    !spiIn.nss [*6];
  endsequence
  idle_oe_a: assert property (spiIn.nss [*4] |-> !misoOe)
    else $error("miso driven while deselected");
  busy_oe_a: assert property (!spiIn.nss [*4] |-> misoOe)
    else $error("miso not driven in frame");
  miso_edge_a: assert property ($changed(miso) |-> !spiIn.sck && $past(!spiIn.sck, 2))
    else $error("miso moved away from a falling sck");
  serial_live_a: assert property (demodValid && !packetMode && opMode == MODE_RX
    |=> serialDataPin == $past(demodBit))
    else $error("live data pin wrong");
  overrun_set_a: assert property ($rose(queueOverrun) |-> $past(queueFull))
    else $error("overrun without full queue");
  overrun_hold_a: assert property (nssIdle ##0 queueOverrun |=> queueOverrun)
    else $error("overrun lost without a write");
  nonempty_hold_a: assert property (nssBusy |=> $stable(queueNonempty))
    else $error("not-empty moved inside a frame");
  full_nonempty_a: assert property (nssIdle ##0 queueFull |-> queueNonempty)
    else $error("full but reported empty");
endmodule
`default_nettype wire

/* File: sim/spi_host_model.sv */
// Host master model for the serial port, clock polarity 0 and phase 0
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
  import spi_fifo_port_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic misoWire, // Resolved data from the port
  output var spiPins_s pins // SCK, NSS, MOSI
);
  initial pins = '{sck: 1'b0, nss: 1'b1, mosi: 1'b0};
  // Frame edges, with a half sck period of settling after the NSS change
  task automatic select(input logic on);
    @(posedge ref_clk);
    pins.nss <= !on;
    pins.mosi <= !pins.mosi;
    repeat (8) @(posedge ref_clk);
  endtask
  // One byte, MSB first, 160 ns sck; sck idles low between frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      pins.mosi <= tx[i];
      repeat (8) @(posedge ref_clk);
      pins.sck <= 1'b1;
      rx[i] = misoWire;
      repeat (8) @(posedge ref_clk);
      pins.sck <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Bench: register access, queue flags, overrun, mode clearing, live data
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import spi_fifo_port_pkg::*;
  ;
  logic ref_clk;
  logic rst;
  opMode_e opMode;
  logic packetMode;
  logic demodBit;
  logic demodValid;
  spiPins_s spiIn;
  logic miso, misoOe, serialDataPin, queueNonempty, queueFull, queueOverrun, queueLevelFlag;
  wire logic misoWire;
  assign misoWire = misoOe ? miso : 1'bz;
  int bad_count = 0;
  int n_compared = 0;
  logic [7:0] rd;
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  spi_register_fifo_port DUT (.ref_clk(ref_clk), .rst(rst), .spiIn(spiIn), .miso(miso),
    .misoOe(misoOe), .opMode(opMode), .packetMode(packetMode), .demodBit(demodBit),
    .demodValid(demodValid), .serialDataPin(serialDataPin), .queueNonempty(queueNonempty),
    .queueFull(queueFull), .queueOverrun(queueOverrun), .queueLevelFlag(queueLevelFlag));
  spi_host_model HOST (.ref_clk(ref_clk), .misoWire(misoWire), .pins(spiIn));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic flag(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic start(input logic [7:0] addr);
    HOST.select(1'b1);
    HOST.xfer(addr, rd);
  endtask
  task automatic xb(input logic [7:0] tx, input logic [7:0] exp);
    HOST.xfer(tx, rd);
    check(rd, exp);
  endtask
  // First demodulated bit must land in the top bit of the queued byte
  task automatic push(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge ref_clk);
      demodBit <= b[i];
      demodValid <= 1'b1;
      @(posedge ref_clk);
      demodValid <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic mode(input opMode_e m);
    opMode <= m;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic s_regs();
    start(8'h3c);
    xb(8'h00, THRESH_RESET);
    HOST.select(1'b0);
    start(8'h90);
    xb(8'h11, REG_RESET);
    xb(8'h22, REG_RESET);
    HOST.select(1'b0);
    start(8'h10);
    xb(8'h00, 8'h11);
    xb(8'h00, 8'h22);
    HOST.select(1'b0);
    start(8'hbc);
    xb(8'h01, THRESH_RESET);
    HOST.select(1'b0);
  endtask
  task automatic s_queue();
    mode(MODE_RX);
    push(8'h81);
    flag(queueNonempty, 1'b1);
    flag(queueLevelFlag, 1'b0);
    push(8'h35);
    flag(queueLevelFlag, 1'b1);
    push(8'ha5);
    mode(MODE_STDBY);
    start(8'h00);
    xb(8'h00, 8'h81);
    xb(8'h00, 8'h35);
    flag(queueNonempty, 1'b1);
    HOST.select(1'b0);
    flag(queueNonempty, 1'b1);
    start(8'h00);
    xb(8'h00, 8'ha5);
    flag(queueNonempty, 1'b1);
    HOST.select(1'b0);
    flag(queueNonempty, 1'b0);
    start(8'h00);
    xb(8'h00, EMPTY_READ);
    HOST.select(1'b0);
    flag(queueNonempty, 1'b0);
  endtask
  task automatic s_full();
    mode(MODE_RX);
    push(8'h81);
    mode(MODE_FS);
    mode(MODE_RX);
    flag(queueNonempty, 1'b1);
    mode(MODE_SLEEP);
    mode(MODE_STDBY);
    flag(queueNonempty, 1'b1);
    mode(MODE_RX);
    flag(queueNonempty, 1'b0);
    for (int i = 0; i < 65; i++)
      push(8'h18);
    flag(queueFull, 1'b0);
    push(8'h18);
    flag(queueFull, 1'b1);
    flag(queueOverrun, 1'b0);
    push(8'h66);
    flag(queueOverrun, 1'b1);
    start(8'ha8);
    xb(8'h10, 8'hf0);
    HOST.select(1'b0);
    flag(queueOverrun, 1'b0);
    flag(queueNonempty, 1'b0);
  endtask
  task automatic s_cont();
    packetMode <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      demodBit <= i[0];
      demodValid <= 1'b1;
      @(posedge ref_clk);
      demodValid <= 1'b0;
      @(posedge ref_clk);
      flag(serialDataPin, i[0]);
    end
    repeat (4) @(posedge ref_clk);
    flag(queueNonempty, 1'b0);
  endtask
  initial
  begin
    rst <= 1'b1;
    opMode <= MODE_STDBY;
    packetMode <= 1'b1;
    demodBit <= 1'b0;
    demodValid <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    s_regs();
    s_queue();
    s_full();
    s_cont();
    print_verdict();
  end
endmodule
bind spi_register_fifo_port spi_port_checker CHK (.ref_clk(ref_clk), .rst(rst),
  .spiIn(spiIn), .miso(miso), .misoOe(misoOe), .opMode(opMode), .packetMode(packetMode),
  .demodBit(demodBit), .demodValid(demodValid), .serialDataPin(serialDataPin),
  .queueNonempty(queueNonempty), .queueFull(queueFull), .queueOverrun(queueOverrun),
  .queueLevelFlag(queueLevelFlag));
`default_nettype wire
